// file: src/emon_pkg.sv
// Behaviour
// - overrun flag set on unacknowledged repeat change
// - sync loss unless period is 32-frame multiple
// - changed frame index held in status bits
// - status read acknowledges and re-arms change
// - high coefficient read acknowledges availability
// - coefficient bits split high and low registers
// - low register top bit flags final coefficient
// - sign, exponent, mantissa expand to 18 bits
// - auxiliary coefficient bits 9:2 in aux register
// - monitors follow selected monitor channel field
// - three PCM sample monitors for chosen channel
// - log level, 191 max, 16 codes per 6 dB
// - 184 is 0 dBm0, 1 is -69, 0 silent
// - request bits clear on read, masked never set
// - old-value register keeps pre-change frame data
package emon_pkg;
  // register indices, byte address is four times the index
  localparam logic [6:0] IDX_IRQ_REQUEST = 7'h08;
  localparam logic [6:0] IDX_SEND_IN_LEVEL = 7'h1e;
  localparam logic [6:0] IDX_SEND_IN_SAMPLE = 7'h29;
  localparam logic [6:0] IDX_SEND_OUT_SAMPLE = 7'h2a;
  localparam logic [6:0] IDX_RECV_IN_SAMPLE = 7'h2b;
  localparam logic [6:0] IDX_OLD_VALUE = 7'h68;
  localparam logic [6:0] IDX_NEW_VALUE = 7'h69;
  localparam logic [6:0] IDX_CHANGE_STATUS = 7'h6a;
  localparam logic [6:0] IDX_POLL_STATUS = 7'h6e;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h70;
  localparam logic [6:0] IDX_MON_CONTROL = 7'h71;
  localparam logic [6:0] IDX_COEFFICIENT_BITS_HIGH = 7'h7b;
  localparam logic [6:0] IDX_COEFFICIENT_BITS_LOW = 7'h7c;
  localparam logic [6:0] IDX_COEFFICIENT_BITS_AUX = 7'h7d;
  // interrupt source bit positions, shared by request, mask and poll
  localparam int IRQ_MONITOR = 0;
  localparam int IRQ_CHANGE = 1;
  localparam int IRQ_COEFFICIENT_BITS = 2;
  localparam int IRQ_SYNC = 3;
  localparam int IRQ_BITS = 4;
  // field positions
  localparam int CHG_OVERRUN_BIT = 6;
  localparam int CHG_SYNC_BIT = 5;
  localparam int MON_VALID_BIT = 7;
  localparam int COEFFICIENT_BITS_FINAL_BIT = 7;
  // reset values
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [4:0] MON_CHANNEL_RESET = 5'h00;
  localparam logic SYNC_LOSS_RESET = 1'b1;
  // level scale: offset removed from raw log code so full scale lands on 191
  localparam logic [7:0] LEVEL_OFFSET = 8'h40;
  localparam logic [7:0] LEVEL_MIN_CODE = 8'h01;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [4:0] frame;
    logic [7:0] old_value;
    logic [7:0] new_value;
  } emon_change_type;

  typedef struct packed {
    logic [13:0] bits;
    logic final_flag;
    logic [9:0] aux;
  } emon_coefficient_bits_type;

  typedef struct packed {
    logic [7:0] send_in;
    logic [7:0] send_out;
    logic [7:0] recv_in;
    logic [15:0] level_mag;
  } emon_sample_type;
endpackage

// file: src/emon_status_readout.sv
`timescale 1ns/1ns
module emon_status_readout (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // user channel change unit
  input wire logic change_event_i,
  input wire emon_pkg::emon_change_type change_data_i,
  input wire logic frame_strobe_i,
  input wire logic frame_sync_pulse_i,
  // adaptive filter coefficient readout
  input wire logic coefficient_bits_event_i,
  input wire emon_pkg::emon_coefficient_bits_type coefficient_bits_data_i,
  // channel monitor
  input wire logic monitor_update_i,
  input wire emon_pkg::emon_sample_type monitor_data_i,
  output logic [4:0] monitor_channel_select_o,
  // derived values and interrupt
  output logic [17:0] coefficient_linear_o,
  output logic irq_o
);

  // expand sign/exponent/mantissa to an 18-bit sign-magnitude value
  function automatic logic [17:0] expand_coefficient_bits(input logic [13:0] c);
    logic [16:0] mag;
    mag = 17'h00000;
    // exponent zero keeps the mantissa as is, with no hidden leading one
    if (c[12:10] == 3'h0) begin
      mag = {7'h00, c[9:0]};
    end else begin
      mag = 17'({6'h00, 1'b1, c[9:0]} << (c[12:10] - 3'h1));
    end
    return {c[13], mag};
  endfunction

  // log level code: 16 codes per octave, i.e. per 6 dB
  function automatic logic [7:0] encode_level(input logic [15:0] mag);
    logic [3:0] pos;
    logic [15:0] norm;
    logic [7:0] raw;
    pos = 4'h0;
    norm = 16'h0000;
    raw = 8'h00;
    for (int i = 0; i < 16; i++) begin
      if (mag[i]) begin
        pos = 4'(i);
      end
    end
    norm = 16'(mag << (4'hf - pos));
    // leading one position gives the octave, the next four bits the step
    raw = {pos, norm[14:11]};
    // codes at or below the offset floor at the lowest nonzero code
    if (mag == 16'h0000) begin
      return 8'h00;
    end else if (raw <= emon_pkg::LEVEL_OFFSET) begin
      return emon_pkg::LEVEL_MIN_CODE;
    end
    return 8'(raw - emon_pkg::LEVEL_OFFSET);
  endfunction

  // number of interrupt sources, shared by request, mask and poll
  localparam int IRQ_BITS_W = emon_pkg::IRQ_BITS;

  logic [6:0] aw_index;
  logic aw_ok;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic wr_fire;
  logic ar_fire;
  logic [6:0] ar_index;
  logic ar_ok;
  logic [31:0] next_rdata;
  logic next_rerr;
  logic wr_low;
  logic ack_change;
  logic ack_coefficient_bits;
  logic ack_irq;
  logic [IRQ_BITS_W-1:0] irq_request;
  logic [IRQ_BITS_W-1:0] irq_mask;
  logic [IRQ_BITS_W-1:0] poll;
  logic [IRQ_BITS_W-1:0] events;
  logic [IRQ_BITS_W-1:0] req_clear;
  emon_pkg::emon_change_type change_held;
  logic overrun;
  logic sync_loss;
  logic [4:0] frame_count;
  logic [4:0] next_frame_count;
  logic sync_event;
  emon_pkg::emon_coefficient_bits_type coefficient_bits_held;
  emon_pkg::emon_sample_type sample_held;
  logic [7:0] level_code;
  logic monitor_valid;
  // pending flags behind the change and coefficient poll bits
  logic change_pending;
  logic coefficient_bits_pending;

  // read address decode; upper address bits must be zero
  // misaligned or out-of-range addresses answer with an error
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign ar_index = s_axi_araddr_i[8:2];
  assign ar_ok = (s_axi_araddr_i[31:9] == 23'h000000) && (s_axi_araddr_i[1:0] == 2'h0);
  assign wr_fire = aw_full && w_full && !s_axi_bvalid_o;
  assign wr_low = wr_fire && aw_ok && w_strb[0];

  // read side effects: acknowledges happen when the address is taken
  assign ack_change = ar_fire && ar_ok && (ar_index == emon_pkg::IDX_CHANGE_STATUS);
  assign ack_coefficient_bits = ar_fire && ar_ok && (ar_index == emon_pkg::IDX_COEFFICIENT_BITS_HIGH);
  assign ack_irq = ar_fire && ar_ok && (ar_index == emon_pkg::IDX_IRQ_REQUEST);

  // read data mux
  always_comb begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    if (!ar_ok) begin
      next_rerr = 1'b1;
    end else begin
      case (ar_index)
        emon_pkg::IDX_IRQ_REQUEST: next_rdata[IRQ_BITS_W-1:0] = irq_request;
        emon_pkg::IDX_IRQ_MASK: next_rdata[IRQ_BITS_W-1:0] = irq_mask;
        emon_pkg::IDX_POLL_STATUS: next_rdata[IRQ_BITS_W-1:0] = poll;
        emon_pkg::IDX_SEND_IN_LEVEL: next_rdata[7:0] = level_code;
        emon_pkg::IDX_SEND_IN_SAMPLE: next_rdata[7:0] = sample_held.send_in;
        emon_pkg::IDX_SEND_OUT_SAMPLE: next_rdata[7:0] = sample_held.send_out;
        emon_pkg::IDX_RECV_IN_SAMPLE: next_rdata[7:0] = sample_held.recv_in;
        emon_pkg::IDX_OLD_VALUE: next_rdata[7:0] = change_held.old_value;
        emon_pkg::IDX_NEW_VALUE: next_rdata[7:0] = change_held.new_value;
        emon_pkg::IDX_CHANGE_STATUS: begin
          next_rdata[emon_pkg::CHG_OVERRUN_BIT] = overrun;
          next_rdata[emon_pkg::CHG_SYNC_BIT] = sync_loss;
          next_rdata[4:0] = change_held.frame;
        end
        emon_pkg::IDX_MON_CONTROL: begin
          next_rdata[emon_pkg::MON_VALID_BIT] = monitor_valid;
          next_rdata[4:0] = monitor_channel_select_o;
        end
        emon_pkg::IDX_COEFFICIENT_BITS_HIGH: next_rdata[7:0] = coefficient_bits_held.bits[13:6];
        emon_pkg::IDX_COEFFICIENT_BITS_LOW: begin
          next_rdata[emon_pkg::COEFFICIENT_BITS_FINAL_BIT] = coefficient_bits_held.final_flag;
          next_rdata[5:0] = coefficient_bits_held.bits[5:0];
        end
        emon_pkg::IDX_COEFFICIENT_BITS_AUX: next_rdata[7:0] = coefficient_bits_held.aux[9:2];
        default: next_rerr = 1'b1;
      endcase
    end
  end

  // read channel: one cycle from address taken to data valid
  // arready stays low until the answer is taken, so one read is open
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= emon_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= next_rerr ? emon_pkg::RESP_SLVERR : emon_pkg::RESP_OKAY;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // write address capture
  // address held until the response is taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      aw_full <= 1'b0;
      aw_index <= 7'h00;
      aw_ok <= 1'b0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_full <= 1'b1;
      aw_index <= s_axi_awaddr_i[8:2];
      aw_ok <= (s_axi_awaddr_i[31:9] == 23'h000000) && (s_axi_awaddr_i[1:0] == 2'h0);
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_awready_o <= 1'b1;
      aw_full <= 1'b0;
    end
  end

  // write data capture
  // data and strobes held until the response is taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_wready_o <= 1'b1;
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_full <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_wready_o <= 1'b1;
      w_full <= 1'b0;
    end
  end

  // write response; only mask, request and monitor control accept writes
  // bvalid blocks a second write until the response is taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= emon_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      if (aw_ok && (aw_index == emon_pkg::IDX_IRQ_MASK || aw_index == emon_pkg::IDX_IRQ_REQUEST
          || aw_index == emon_pkg::IDX_MON_CONTROL)) begin
        s_axi_bresp_o <= emon_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp_o <= emon_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask <= emon_pkg::IRQ_MASK_RESET;
    end else if (wr_low && aw_index == emon_pkg::IDX_IRQ_MASK) begin
      irq_mask <= w_data[IRQ_BITS_W-1:0];
    end
  end

  // monitor control: channel select, valid flag cleared by writing zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      monitor_channel_select_o <= emon_pkg::MON_CHANNEL_RESET;
      monitor_valid <= 1'b0;
    end else begin
      if (wr_low && aw_index == emon_pkg::IDX_MON_CONTROL) begin
        monitor_channel_select_o <= w_data[4:0];
        if (!w_data[emon_pkg::MON_VALID_BIT]) begin
          monitor_valid <= 1'b0;
        end
      end
      if (monitor_update_i) begin
        monitor_valid <= 1'b1; // set wins over clear
      end
    end
  end

  // monitor samples of the selected channel, level encoded on capture
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_held <= '0;
      level_code <= 8'h00;
    end else if (monitor_update_i) begin
      sample_held <= monitor_data_i;
      level_code <= encode_level(monitor_data_i.level_mag);
    end
  end

  // sync supervision: frames between sync pulses must be a multiple of 32
  // a strobe in the sync cycle still counts toward the period
  assign next_frame_count = 5'(frame_count + {4'h0, frame_strobe_i});
  assign sync_event = frame_sync_pulse_i && ((next_frame_count != 5'h00) != sync_loss);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_count <= 5'h00;
      sync_loss <= emon_pkg::SYNC_LOSS_RESET;
    end else if (frame_sync_pulse_i) begin
      frame_count <= 5'h00;
      sync_loss <= (next_frame_count != 5'h00);
    end else begin
      frame_count <= next_frame_count;
    end
  end

  // change capture: first change held until acknowledged, repeats flag overrun
  // an acknowledge in the event cycle re-arms, so the new change is kept
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      change_held <= '0;
      overrun <= 1'b0;
      change_pending <= 1'b0;
    end else if (change_event_i && (ack_change || !change_pending)) begin
      change_held <= change_data_i;
      overrun <= 1'b0;
      change_pending <= 1'b1;
    end else if (change_event_i) begin
      overrun <= 1'b1;
    end else if (ack_change) begin
      overrun <= 1'b0;
      change_pending <= 1'b0;
    end
  end

  // coefficient capture: new coefficient accepted once the previous is acknowledged
  // an unacknowledged coefficient is kept, later ones are dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      coefficient_bits_held <= '0;
      coefficient_linear_o <= 18'h00000;
      coefficient_bits_pending <= 1'b0;
    end else if (coefficient_bits_event_i && (ack_coefficient_bits || !coefficient_bits_pending)) begin
      coefficient_bits_held <= coefficient_bits_data_i;
      coefficient_linear_o <= expand_coefficient_bits(coefficient_bits_data_i.bits);
      coefficient_bits_pending <= 1'b1;
    end else if (ack_coefficient_bits) begin
      coefficient_bits_pending <= 1'b0;
    end
  end

  // poll bits: pending change and coefficient, live sync loss and monitor valid
  always_comb begin
    poll = '0;
    poll[emon_pkg::IRQ_CHANGE] = change_pending;
    poll[emon_pkg::IRQ_COEFFICIENT_BITS] = coefficient_bits_pending;
    poll[emon_pkg::IRQ_SYNC] = sync_loss;
    poll[emon_pkg::IRQ_MONITOR] = monitor_valid;
  end

  // interrupt sources as one-cycle events
  // change and coefficient events count only when they are captured
  always_comb begin
    events = '0;
    events[emon_pkg::IRQ_CHANGE] = change_event_i && (ack_change || !change_pending);
    events[emon_pkg::IRQ_COEFFICIENT_BITS] = coefficient_bits_event_i && (ack_coefficient_bits || !coefficient_bits_pending);
    events[emon_pkg::IRQ_SYNC] = sync_event && !sync_loss;
    events[emon_pkg::IRQ_MONITOR] = monitor_update_i;
    req_clear = ack_irq ? {IRQ_BITS_W{1'b1}} : '0;
    if (wr_low && aw_index == emon_pkg::IDX_IRQ_REQUEST) begin
      req_clear = req_clear | w_data[IRQ_BITS_W-1:0];
    end
  end

  // sticky request bits: masked sources never set, set wins over clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_request <= '0;
    end else begin
      irq_request <= (irq_request & ~req_clear) | (events & irq_mask);
    end
  end

  // level interrupt from registered request bits
  // computed from the next request value so irq_o lines up with it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_request & ~req_clear) | (events & irq_mask)) & irq_mask);
    end
  end

endmodule

// file: tb/emon_status_readout_asserts.sv
`timescale 1ns/1ns
module emon_status_readout_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // events and derived outputs
  input wire logic change_event_i,
  input wire logic frame_sync_pulse_i,
  input wire logic monitor_update_i,
  input wire logic coefficient_bits_event_i,
  input wire emon_pkg::emon_coefficient_bits_type coefficient_bits_data_i,
  input wire logic [4:0] monitor_channel_select_o,
  input wire logic [17:0] coefficient_linear_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ar_take;
  logic quiet;
  logic quiet_q;
  logic [17:0] lin_exp;
  // read handshake and no event pending
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
  assign quiet = !(change_event_i || frame_sync_pulse_i || monitor_update_i || coefficient_bits_event_i);
  // expansion of last cycle's coefficient, so it lines up with a capture
  always_ff @(posedge clk_i) begin
    quiet_q <= quiet;
    lin_exp <= {coefficient_bits_data_i.bits[13], (coefficient_bits_data_i.bits[12:10] == 3'h0) ?
      {7'h0, coefficient_bits_data_i.bits[9:0]} :
      (17'({1'b1, coefficient_bits_data_i.bits[9:0]}) << (coefficient_bits_data_i.bits[12:10] - 3'h1))};
  end
  AST_READ_ANSWER: assert property (ar_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer missing");
  AST_READ_HOLD: assert property (
    s_axi_rvalid_o && s_axi_rready_i |-> !s_axi_arready_o ##1 (!s_axi_rvalid_o && s_axi_arready_o))
    else $error("read answer not released");
  AST_READ_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_BAD_ADDR: assert property (ar_take && s_axi_araddr_i[31:9] != 23'h0 |=>
    s_axi_rresp_o == emon_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("bad address answered");
  AST_WRITE_ANSWER: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write answer missing");
  AST_WRITE_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer open");
  AST_SELECT_BY_WRITE: assert property (
    $changed(monitor_channel_select_o) |-> ##[0:2] s_axi_bvalid_o)
    else $error("channel select moved without write");
  AST_COEFFICIENT_BITS_EXPAND: assert property ($changed(coefficient_linear_o) |->
    $past(coefficient_bits_event_i) && coefficient_linear_o == lin_exp)
    else $error("coefficient expansion wrong");
  AST_IRQ_READ_CLEAR: assert property (
    ar_take && s_axi_araddr_i == 32'h20 && quiet && quiet_q |=> !irq_o)
    else $error("interrupt stays after request read");
  // main scenarios
  cover property (ar_take && s_axi_araddr_i == 32'h1a8);
  cover property ($rose(irq_o));
  cover property (coefficient_bits_event_i);
endmodule

// file: tb/emon_status_readout_tb.sv
`timescale 1ns/1ns
module emon_status_readout_tb;
  logic clk, rst, awv, wv, arv, ce, fs, fsp, ke, mu, awr, wr, bv, arr, rv, irq;
  logic [31:0] awa, wd, ara, rd;
  logic [1:0] br, rr;
  logic [4:0] sel;
  logic [17:0] lin;
  emon_pkg::emon_change_type cd;
  emon_pkg::emon_coefficient_bits_type kd;
  emon_pkg::emon_sample_type md;
  int error_cnt, total_checks;
  // block under test
  emon_status_readout dut_u (
    .clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .change_event_i(ce),
    .change_data_i(cd), .frame_strobe_i(fs), .frame_sync_pulse_i(fsp), .coefficient_bits_event_i(ke),
    .coefficient_bits_data_i(kd), .monitor_update_i(mu), .monitor_data_i(md),
    .monitor_channel_select_o(sel), .coefficient_linear_o(lin), .irq_o(irq));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one bus read, bounded wait for the answer
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    ara <= a;
    arv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      n++;
    end while (!rv && n < 50);
    if (n >= 50) error_cnt++;
    d = rd;
    r = rr;
  endtask
  // read a register by index and compare masked bits
  task automatic rchk(input logic [6:0] i, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd_reg({23'h0, i, 2'h0}, d, r);
    chk(d & {24'h0, m}, {24'h0, e});
    chk({30'h0, r}, {30'h0, emon_pkg::RESP_OKAY});
  endtask
  // one bus write, address and data offered together
  task automatic wr_reg(input logic [6:0] i, input logic [7:0] v, input logic bad);
    int n;
    awa <= {23'h0, i, 2'h0};
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      n++;
    end while (!bv && n < 50);
    if (n >= 50) error_cnt++;
    chk({30'h0, br}, {30'h0, bad ? emon_pkg::RESP_SLVERR : emon_pkg::RESP_OKAY});
  endtask
  // event pulses, each ends once outputs have settled
  task automatic chg(input emon_pkg::emon_change_type v);
    @(posedge clk);
    cd <= v;
    ce <= 1'b1;
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
  endtask
  task automatic coefficient_bits(input emon_pkg::emon_coefficient_bits_type v);
    @(posedge clk);
    kd <= v;
    ke <= 1'b1;
    @(posedge clk);
    ke <= 1'b0;
    @(posedge clk);
  endtask
  task automatic mon(input emon_pkg::emon_sample_type v);
    @(posedge clk);
    md <= v;
    mu <= 1'b1;
    @(posedge clk);
    mu <= 1'b0;
    @(posedge clk);
  endtask
  task automatic frames(input int n, input logic sync);
    repeat (n) begin
      @(posedge clk);
      fs <= 1'b1;
      @(posedge clk);
      fs <= 1'b0;
    end
    @(posedge clk);
    fsp <= sync;
    @(posedge clk);
    fsp <= 1'b0;
    @(posedge clk);
  endtask
  // reset values, unmapped and read-only places
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rchk(emon_pkg::IDX_IRQ_MASK, 8'hff, 8'h00);
    rchk(emon_pkg::IDX_MON_CONTROL, 8'hff, 8'h00);
    rchk(emon_pkg::IDX_CHANGE_STATUS, 8'h7f, 8'h20);
    rd_reg(32'h200, d, r);
    chk({d[29:0], r}, {30'h0, emon_pkg::RESP_SLVERR});
    wr_reg(emon_pkg::IDX_SEND_IN_SAMPLE, 8'h55, 1'b1);
  endtask
  // change capture, overrun, acknowledge, masking
  task automatic t_change();
    wr_reg(emon_pkg::IDX_IRQ_MASK, 8'h0f, 1'b0);
    chg({5'h13, 8'ha5, 8'h5a});
    chk({31'h0, irq}, 32'h1);
    rchk(emon_pkg::IDX_OLD_VALUE, 8'hff, 8'ha5);
    rchk(emon_pkg::IDX_NEW_VALUE, 8'hff, 8'h5a);
    rchk(emon_pkg::IDX_POLL_STATUS, 8'h02, 8'h02);
    chg({5'h02, 8'h11, 8'h22});
    rchk(emon_pkg::IDX_CHANGE_STATUS, 8'h7f, 8'h73);
    rchk(emon_pkg::IDX_CHANGE_STATUS, 8'h7f, 8'h33);
    rchk(emon_pkg::IDX_POLL_STATUS, 8'h02, 8'h00);
    rchk(emon_pkg::IDX_OLD_VALUE, 8'hff, 8'ha5);
    rchk(emon_pkg::IDX_IRQ_REQUEST, 8'h0f, 8'h02);
    chk({31'h0, irq}, 32'h0);
    rchk(emon_pkg::IDX_IRQ_REQUEST, 8'h0f, 8'h00);
    wr_reg(emon_pkg::IDX_IRQ_MASK, 8'h00, 1'b0);
    chg({5'h07, 8'h3c, 8'hc3});
    chk({31'h0, irq}, 32'h0);
    rchk(emon_pkg::IDX_IRQ_REQUEST, 8'h0f, 8'h00);
    rchk(emon_pkg::IDX_CHANGE_STATUS, 8'h7f, 8'h27);
  endtask
  // every exponent, split fields, final flag, acknowledge
  task automatic t_coefficient_bits();
    logic [13:0] b;
    logic [16:0] m;
    wr_reg(emon_pkg::IDX_IRQ_MASK, 8'h0f, 1'b0);
    for (int e = 0; e < 8; e++) begin
      b = {e[0], e[2:0], 10'h2b5};
      coefficient_bits({b, e == 7, 10'h3c9});
      m = (e == 0) ? {7'h0, b[9:0]} : (17'({1'b1, b[9:0]}) << (e - 1));
      chk({14'h0, lin}, {14'h0, b[13], m});
      rchk(emon_pkg::IDX_COEFFICIENT_BITS_AUX, 8'hff, 8'hf2);
      rchk(emon_pkg::IDX_COEFFICIENT_BITS_LOW, 8'hbf, {e == 7, 1'b0, b[5:0]});
      rchk(emon_pkg::IDX_COEFFICIENT_BITS_HIGH, 8'hff, b[13:6]);
      rchk(emon_pkg::IDX_POLL_STATUS, 8'h04, 8'h00);
    end
    coefficient_bits({14'h1234, 1'b0, 10'h0});
    coefficient_bits({14'h0abc, 1'b0, 10'h0});
    rchk(emon_pkg::IDX_COEFFICIENT_BITS_HIGH, 8'hff, 8'h48);
    rchk(emon_pkg::IDX_IRQ_REQUEST, 8'h04, 8'h04);
  endtask
  // channel select, samples, level scale, valid flag
  task automatic t_mon();
    logic [15:0] mg [5] = '{16'h0000, 16'h0001, 16'hc000, 16'h6000, 16'hffff};
    logic [7:0] lc [5] = '{8'h00, 8'h01, 8'hb8, 8'ha8, 8'hbf};
    wr_reg(emon_pkg::IDX_MON_CONTROL, 8'h17, 1'b0);
    chk({27'h0, sel}, 32'h17);
    for (int i = 0; i < 5; i++) begin
      mon({i[7:0], ~i[7:0], 8'h5a ^ i[7:0], mg[i]});
      rchk(emon_pkg::IDX_SEND_IN_SAMPLE, 8'hff, i[7:0]);
      rchk(emon_pkg::IDX_SEND_OUT_SAMPLE, 8'hff, ~i[7:0]);
      rchk(emon_pkg::IDX_RECV_IN_SAMPLE, 8'hff, 8'h5a ^ i[7:0]);
      rchk(emon_pkg::IDX_SEND_IN_LEVEL, 8'hff, lc[i]);
    end
    rchk(emon_pkg::IDX_MON_CONTROL, 8'hff, 8'h97);
    wr_reg(emon_pkg::IDX_MON_CONTROL, 8'h17, 1'b0);
    rchk(emon_pkg::IDX_MON_CONTROL, 8'hff, 8'h17);
  endtask
  // sync period aligned and misaligned, write-one clear
  task automatic t_sync();
    wr_reg(emon_pkg::IDX_IRQ_REQUEST, 8'h0f, 1'b0);
    chk({31'h0, irq}, 32'h0);
    frames(0, 1'b1);
    frames(32, 1'b1);
    rchk(emon_pkg::IDX_CHANGE_STATUS, 8'h20, 8'h00);
    frames(5, 1'b1);
    rchk(emon_pkg::IDX_CHANGE_STATUS, 8'h20, 8'h20);
    chk({31'h0, irq}, 32'h1);
    wr_reg(emon_pkg::IDX_IRQ_REQUEST, 8'h0f, 1'b0);
    rchk(emon_pkg::IDX_IRQ_REQUEST, 8'h0f, 8'h00);
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // watchdog
  initial begin
    #2000000;
    error_cnt++;
    test_done();
  end
  // main sequence
  initial begin
    {rst, awv, wv, arv, ce, fs, fsp, ke, mu} = 9'h100;
    {awa, wd, ara} = '0;
    cd = '0;
    kd = '0;
    md = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_change();
    t_coefficient_bits();
    t_mon();
    t_sync();
    test_done();
  end
endmodule
bind emon_status_readout emon_status_readout_asserts chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .change_event_i(change_event_i),
  .frame_sync_pulse_i(frame_sync_pulse_i), .monitor_update_i(monitor_update_i),
  .coefficient_bits_event_i(coefficient_bits_event_i), .coefficient_bits_data_i(coefficient_bits_data_i),
  .monitor_channel_select_o(monitor_channel_select_o),
  .coefficient_linear_o(coefficient_linear_o), .irq_o(irq_o));
